// file: inc/qcmd_pkg.sv
// Constants for the queued read and log read command decoder.
// Assumes an APB master on pclk and a media engine on the user side.
package qcmd_pkg;
    // ----------------------------------------
    // Register byte addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_FEATURE = 8'h00;
    localparam logic [7:0] ADDR_SECCNT = 8'h04;
    localparam logic [7:0] ADDR_SECNUM = 8'h08;
    localparam logic [7:0] ADDR_CYLLO = 8'h0c;
    localparam logic [7:0] ADDR_CYLHI = 8'h10;
    localparam logic [7:0] ADDR_DEVHEAD = 8'h14;
    localparam logic [7:0] ADDR_COMMAND = 8'h18;
    localparam logic [7:0] ADDR_ERROR = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_CONTROL = 8'h24;
    localparam logic [7:0] ADDR_EVENT = 8'h28;
    localparam logic [7:0] ADDR_TAGSEL = 8'h2c;
    localparam logic [7:0] ADDR_TAGINFO = 8'h30;
    localparam logic [7:0] ADDR_TAGLIMIT = 8'h34;
    localparam logic [7:0] ADDR_TAGLBA = 8'h38;
    // ----------------------------------------
    // Opcodes and fields
    // ----------------------------------------
    localparam logic [7:0] OP_QREAD = 8'h60;
    localparam logic [7:0] OP_LOGREAD = 8'h2f;
    localparam int TAG_HI = 7;
    localparam int TAG_LO = 3;
    localparam int REBUILD_ASSIST_READ_FLAG_BIT = 0;
    localparam int QUEUE_PRIORITY_FIELD_HI = 7;
    localparam int QUEUE_PRIORITY_FIELD_LO = 6;
    localparam logic [1:0] QUEUE_PRIORITY_FIELD_NORMAL = 2'h0;
    localparam logic [1:0] QUEUE_PRIORITY_FIELD_ISOC = 2'h1;
    localparam logic [1:0] QUEUE_PRIORITY_FIELD_HIGH = 2'h2;
    localparam int FUA_BIT = 7;
    localparam int COARSE_BIT = 7;
    localparam int ERR_ABT = 2;
    localparam int ERR_UNC = 6;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int CTL_HOB = 0;
    localparam int CTL_RA_SUP = 1;
    localparam int CTL_RA_EN = 2;
    localparam int CTL_DL_ABORT = 3;
    localparam int CTL_NCQ = 4;
    localparam int CTL_SMART = 5;
    localparam logic [7:0] STATUS_RESET = 8'h40;
    localparam logic [7:0] CONTROL_RESET = 8'h30;
    localparam logic [7:0] LOG_SELFTEST = 8'h06;
    localparam logic [7:0] LOG_HOST_LO = 8'h80;
    localparam logic [7:0] LOG_HOST_HI = 8'h9f;
    localparam logic [15:0] LOG_HOST_SECTORS = 16'h0010;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int FINE_MS = 10;
    localparam int COARSE_MS = 500;
    localparam int FINE_CYCLES = FINE_MS * CLK_MHZ * 1000;
    localparam int COARSE_TICKS = COARSE_MS / FINE_MS;
endpackage

// file: rtl/qcmd_decode.sv
// Queued read and log read command interpreter with APB task file.
// Assumes a media engine that completes tags and streams log blocks.
`timescale 1ns/1ps
module qcmd_decode
(
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Media engine
    output logic [4:0] issue_tag,
    output logic issue_valid,
    output logic issue_fua,
    output logic issue_rebuild_assist_read_flag,
    output logic [47:0] issue_lba,
    output logic [15:0] issue_count,
    input wire logic issue_ready,
    input wire logic done_valid,
    input wire logic [4:0] done_tag,
    input wire logic done_unc,
    input wire logic [47:0] done_fail_lba,
    // Log transfer and interrupt
    output logic log_start,
    output logic [7:0] log_addr,
    output logic [15:0] log_first,
    output logic [15:0] log_count,
    input wire logic log_block_done,
    input wire logic log_last,
    output logic irq
);
    typedef enum logic [2:0] {IDLE = 3'b001, LOGXFER = 3'b010, DONE = 3'b100} state_e;
    state_e state_reg;

    logic [15:0] feat_reg, scnt_reg, snum_reg, cyll_reg, cylh_reg;
    logic [7:0] devhead_reg, error_reg, status_reg, control_reg, tagsel_reg;
    logic [31:0] valid_reg, expired_reg;
    logic [1:0] queue_priority_field_mem [32];
    logic [7:0] icc_mem [32];
    logic fua_mem [32];
    logic [47:0] lba_mem [32];
    logic [12:0] limit_mem [32];
    logic [23:0] tick_cnt_reg;
    logic tick_reg;
    logic [31:0] rdata_next;

    // Byte register shift: the previous byte keeps the prior write
    function automatic logic [15:0] push(input logic [15:0] r, input logic [7:0] b);
        return {r[7:0], b};
    endfunction

    // Fine units of 10 ms; coarse is 50 fine ticks per unit
    // Thirteen bits: the largest coarse limit is 128 times 50 ticks
    function automatic logic [12:0] limit_ticks(input logic [7:0] deadline_time_field);
        logic [12:0] n;
        n = {6'h00, deadline_time_field[6:0]} + 13'h0001;
        if (deadline_time_field[qcmd_pkg::COARSE_BIT])
            return 13'(n * 13'(qcmd_pkg::COARSE_TICKS));
        return n;
    endfunction

    function automatic logic log_valid(input logic [7:0] a, input logic [15:0] cnt,
                                       input logic [15:0] first, input logic [7:0] ctl);
        logic ok;
        ok = 1'b0;
        case (a)
            8'h00, 8'h04, 8'h07, 8'h08, 8'h11, 8'h21, 8'h22, 8'h30: ok = 1'b1;
            8'h03: ok = ctl[qcmd_pkg::CTL_SMART];
            8'h10, 8'h12: ok = ctl[qcmd_pkg::CTL_NCQ];
            8'h15: ok = ctl[qcmd_pkg::CTL_RA_SUP] & ctl[qcmd_pkg::CTL_RA_EN];
            default: ok = (a >= qcmd_pkg::LOG_HOST_LO) && (a <= qcmd_pkg::LOG_HOST_HI)
                          && ctl[qcmd_pkg::CTL_SMART] && (first < qcmd_pkg::LOG_HOST_SECTORS);
        endcase
        if (a == qcmd_pkg::LOG_SELFTEST)
            ok = 1'b0;
        if (cnt == 16'h0000)
            ok = 1'b0;
        return ok;
    endfunction

    wire wr = psel && penable && pwrite;
    wire cmd_wr = wr && paddr == qcmd_pkg::ADDR_COMMAND;
    wire [4:0] new_tag = scnt_reg[qcmd_pkg::TAG_HI:qcmd_pkg::TAG_LO];
    wire [1:0] new_queue_priority_field = scnt_reg[8 + qcmd_pkg::QUEUE_PRIORITY_FIELD_HI:8 + qcmd_pkg::QUEUE_PRIORITY_FIELD_LO];
    wire is_qread = cmd_wr && pwdata[7:0] == qcmd_pkg::OP_QREAD;
    wire is_log = cmd_wr && pwdata[7:0] == qcmd_pkg::OP_LOGREAD;
    wire log_ok = log_valid(snum_reg[7:0], scnt_reg, cyll_reg, control_reg);
    wire q_bad = is_qread && (valid_reg[new_tag] || new_queue_priority_field == 2'h3 || !control_reg[qcmd_pkg::CTL_NCQ]);
    wire hob = control_reg[qcmd_pkg::CTL_HOB];

    // ----------------------------------------
    // Task file writes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            feat_reg <= 16'h0000;
            scnt_reg <= 16'h0000;
            snum_reg <= 16'h0000;
            cyll_reg <= 16'h0000;
            cylh_reg <= 16'h0000;
            devhead_reg <= 8'h00;
            control_reg <= qcmd_pkg::CONTROL_RESET;
            tagsel_reg <= 8'h00;
        end
        else if (done_valid && done_unc)
        begin
            // Failing address loaded into the address bytes
            snum_reg <= {done_fail_lba[31:24], done_fail_lba[7:0]};
            cyll_reg <= {done_fail_lba[39:32], done_fail_lba[15:8]};
            cylh_reg <= {done_fail_lba[47:40], done_fail_lba[23:16]};
        end
        else if (wr)
        begin
            case (paddr)
                qcmd_pkg::ADDR_FEATURE: feat_reg <= push(feat_reg, pwdata[7:0]);
                qcmd_pkg::ADDR_SECCNT: scnt_reg <= push(scnt_reg, pwdata[7:0]);
                qcmd_pkg::ADDR_SECNUM: snum_reg <= push(snum_reg, pwdata[7:0]);
                qcmd_pkg::ADDR_CYLLO: cyll_reg <= push(cyll_reg, pwdata[7:0]);
                qcmd_pkg::ADDR_CYLHI: cylh_reg <= push(cylh_reg, pwdata[7:0]);
                qcmd_pkg::ADDR_DEVHEAD: devhead_reg <= pwdata[7:0];
                qcmd_pkg::ADDR_CONTROL: control_reg <= pwdata[7:0];
                qcmd_pkg::ADDR_TAGSEL: tagsel_reg <= {3'h0, pwdata[4:0]};
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Deadline tick, 10 ms
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_reg <= 24'h000000;
            tick_reg <= 1'b0;
        end
        else if (tick_cnt_reg == 24'(qcmd_pkg::FINE_CYCLES - 1))
        begin
            tick_cnt_reg <= 24'h000000;
            tick_reg <= 1'b1;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 24'h000001;
            tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Per-tag state
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid_reg <= 32'h00000000;
            expired_reg <= 32'h00000000;
            for (int i = 0; i < 32; i++)
            begin
                queue_priority_field_mem[i] <= 2'h0;
                icc_mem[i] <= 8'h00;
                fua_mem[i] <= 1'b0;
                lba_mem[i] <= 48'h0;
                limit_mem[i] <= 13'h0000;
            end
        end
        else
        begin
            for (int i = 0; i < 32; i++)
            begin
                // Only isochronous tags count down
                if (valid_reg[i] && queue_priority_field_mem[i] == qcmd_pkg::QUEUE_PRIORITY_FIELD_ISOC && tick_reg)
                begin
                    if (limit_mem[i] != 13'h0000)
                        limit_mem[i] <= limit_mem[i] - 13'h0001;
                    else
                        expired_reg[i] <= 1'b1;
                end
            end
            if (done_valid)
            begin
                valid_reg[done_tag] <= 1'b0;
                expired_reg[done_tag] <= 1'b0;
            end
            if (is_qread && !q_bad)
            begin
                valid_reg[new_tag] <= 1'b1;
                expired_reg[new_tag] <= 1'b0;
                queue_priority_field_mem[new_tag] <= new_queue_priority_field;
                icc_mem[new_tag] <= feat_reg[7:0];
                fua_mem[new_tag] <= devhead_reg[qcmd_pkg::FUA_BIT];
                lba_mem[new_tag] <= {cylh_reg[15:8], cyll_reg[15:8], snum_reg[15:8],
                                     cylh_reg[7:0], cyll_reg[7:0], snum_reg[7:0]};
                limit_mem[new_tag] <= limit_ticks(feat_reg[7:0]);
            end
        end
    end

    // ----------------------------------------
    // Issue scheduling
    // ----------------------------------------
    logic [31:0] pend_reg;
    logic [15:0] counts [32];
    logic [4:0] pick;
    logic pick_ok;
    always_comb
    begin
        pick = 5'h00;
        pick_ok = 1'b0;
        // Later passes override: high beats isochronous beats normal, lowest tag first
        for (int i = 31; i >= 0; i--)
            if (pend_reg[i] && queue_priority_field_mem[i] == qcmd_pkg::QUEUE_PRIORITY_FIELD_NORMAL)
            begin
                pick = 5'(i);
                pick_ok = 1'b1;
            end
        for (int i = 31; i >= 0; i--)
            if (pend_reg[i] && queue_priority_field_mem[i] == qcmd_pkg::QUEUE_PRIORITY_FIELD_ISOC)
            begin
                pick = 5'(i);
                pick_ok = 1'b1;
            end
        for (int i = 31; i >= 0; i--)
            if (pend_reg[i] && queue_priority_field_mem[i] == qcmd_pkg::QUEUE_PRIORITY_FIELD_HIGH)
            begin
                pick = 5'(i);
                pick_ok = 1'b1;
            end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_reg <= 32'h00000000;
            issue_valid <= 1'b0;
            issue_tag <= 5'h00;
            issue_fua <= 1'b0;
            issue_rebuild_assist_read_flag <= 1'b0;
            issue_lba <= 48'h0;
            issue_count <= 16'h0000;
            for (int i = 0; i < 32; i++)
                counts[i] <= 16'h0000;
        end
        else
        begin
            if (is_qread && !q_bad)
            begin
                pend_reg[new_tag] <= 1'b1;
                counts[new_tag] <= feat_reg;
            end
            if (issue_valid && issue_ready)
                issue_valid <= 1'b0;
            else if (!issue_valid && pick_ok)
            begin
                issue_valid <= 1'b1;
                issue_tag <= pick;
                issue_fua <= fua_mem[pick];
                issue_rebuild_assist_read_flag <= scnt_reg[qcmd_pkg::REBUILD_ASSIST_READ_FLAG_BIT] && control_reg[qcmd_pkg::CTL_RA_SUP]
                              && control_reg[qcmd_pkg::CTL_RA_EN];
                issue_lba <= lba_mem[pick];
                issue_count <= counts[pick];
                pend_reg[pick] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Command state, error and status
    // ----------------------------------------
    wire dl_abort = done_valid && expired_reg[done_tag] && control_reg[qcmd_pkg::CTL_DL_ABORT];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= IDLE;
            error_reg <= 8'h00;
            status_reg <= qcmd_pkg::STATUS_RESET;
            log_start <= 1'b0;
            log_addr <= 8'h00;
            log_first <= 16'h0000;
            log_count <= 16'h0000;
            irq <= 1'b0;
        end
        else
        begin
            log_start <= 1'b0;
            irq <= 1'b0;
            case (state_reg)
                IDLE:
                begin
                    if (is_log && !log_ok)
                    begin
                        error_reg <= 8'h04;
                        status_reg <= qcmd_pkg::STATUS_RESET | 8'h01;
                        irq <= 1'b1;
                    end
                    else if (is_log)
                    begin
                        error_reg <= 8'h00;
                        status_reg <= 8'h80;
                        log_start <= 1'b1;
                        log_addr <= snum_reg[7:0];
                        log_first <= cyll_reg;
                        log_count <= scnt_reg;
                        state_reg <= LOGXFER;
                    end
                    else if (q_bad || dl_abort)
                    begin
                        error_reg <= 8'h04;
                        status_reg <= qcmd_pkg::STATUS_RESET | 8'h01;
                        irq <= 1'b1;
                    end
                    else if (done_valid && done_unc)
                    begin
                        error_reg <= 8'h40;
                        status_reg <= qcmd_pkg::STATUS_RESET | 8'h01;
                        irq <= 1'b1;
                    end
                    else if (done_valid)
                    begin
                        error_reg <= 8'h00;
                        status_reg <= qcmd_pkg::STATUS_RESET;
                        irq <= 1'b1;
                    end
                end
                LOGXFER:
                begin
                    status_reg <= 8'h48;
                    if (log_block_done)
                    begin
                        irq <= 1'b1;
                        if (log_last)
                            state_reg <= DONE;
                    end
                end
                DONE:
                begin
                    status_reg <= qcmd_pkg::STATUS_RESET;
                    state_reg <= IDLE;
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb
    begin
        rdata_next = 32'h00000000;
        case (paddr)
            qcmd_pkg::ADDR_FEATURE: rdata_next = {24'h0, hob ? feat_reg[15:8] : feat_reg[7:0]};
            qcmd_pkg::ADDR_SECCNT: rdata_next = {24'h0, hob ? scnt_reg[15:8] : scnt_reg[7:0]};
            qcmd_pkg::ADDR_SECNUM: rdata_next = {24'h0, hob ? snum_reg[15:8] : snum_reg[7:0]};
            qcmd_pkg::ADDR_CYLLO: rdata_next = {24'h0, hob ? cyll_reg[15:8] : cyll_reg[7:0]};
            qcmd_pkg::ADDR_CYLHI: rdata_next = {24'h0, hob ? cylh_reg[15:8] : cylh_reg[7:0]};
            qcmd_pkg::ADDR_DEVHEAD: rdata_next = {24'h0, devhead_reg};
            qcmd_pkg::ADDR_ERROR: rdata_next = {24'h0, error_reg};
            qcmd_pkg::ADDR_STATUS: rdata_next = {24'h0, status_reg};
            qcmd_pkg::ADDR_CONTROL: rdata_next = {24'h0, control_reg};
            qcmd_pkg::ADDR_EVENT: rdata_next = valid_reg;
            qcmd_pkg::ADDR_TAGSEL: rdata_next = {24'h0, tagsel_reg};
            qcmd_pkg::ADDR_TAGINFO: rdata_next = {20'h0, expired_reg[tagsel_reg[4:0]],
                                     fua_mem[tagsel_reg[4:0]], queue_priority_field_mem[tagsel_reg[4:0]],
                                     icc_mem[tagsel_reg[4:0]]};
            qcmd_pkg::ADDR_TAGLIMIT: rdata_next = {19'h0, limit_mem[tagsel_reg[4:0]]};
            qcmd_pkg::ADDR_TAGLBA: rdata_next = lba_mem[tagsel_reg[4:0]][31:0];
            default: rdata_next = 32'h00000000;
        endcase
    end

    wire mapped = paddr <= qcmd_pkg::ADDR_TAGLBA && paddr[1:0] == 2'h0;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            // No wait state: answer registered from the setup cycle
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable)
                prdata <= rdata_next;
        end
    end

    a_log_abort_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == IDLE && is_log && !log_ok) |=> (error_reg == 8'h04 && status_reg[0] && !status_reg[7]))
        else $error("log abort flags wrong");
    a_selftest_abort: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == IDLE && is_log && snum_reg[7:0] == 8'h06) |=> !log_start && error_reg[2])
        else $error("log 06h not aborted");
    a_log_block_irq: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == LOGXFER && log_block_done) |=> irq)
        else $error("no irq per log block");
    a_log_start_args: assert property (@(posedge pclk) disable iff (!presetn)
        log_start |-> state_reg == LOGXFER && log_count == $past(scnt_reg) && log_first == $past(cyll_reg))
        else $error("log start arguments wrong");
    a_tag_release: assert property (@(posedge pclk) disable iff (!presetn)
        (done_valid && !(is_qread && !q_bad && new_tag == done_tag)) |=> !valid_reg[$past(done_tag)])
        else $error("tag not released");
    a_rebuild_assist_read_flag_gate: assert property (@(posedge pclk) disable iff (!presetn)
        issue_rebuild_assist_read_flag |-> control_reg[qcmd_pkg::CTL_RA_EN] || $past(control_reg[qcmd_pkg::CTL_RA_EN]))
        else $error("rebuild assist not gated");
    a_fine_limit: assert property (@(posedge pclk) disable iff (!presetn)
        (is_qread && !q_bad && !feat_reg[7]) |=> limit_mem[$past(new_tag)] == {6'h0, $past(feat_reg[6:0])} + 13'h1)
        else $error("fine limit wrong");
    a_qread_opcode: assert property (@(posedge pclk) disable iff (!presetn)
        (is_qread && !q_bad) |=> valid_reg[$past(new_tag)] && pend_reg[$past(new_tag)])
        else $error("queued read not accepted");
endmodule

// file: verif/qcmd_media_model.sv
// Media and log engine model on the decoder's user side.
// Assumes it shares pclk and presetn with the decoder.
`timescale 1ns/1ps
module qcmd_media_model
(
    // Clock, reset and engine handshakes
    input wire logic pclk,
    input wire logic presetn,
    input wire logic issue_valid,
    input wire logic [4:0] issue_tag,
    output logic issue_ready,
    output logic done_valid,
    output logic [4:0] done_tag,
    output logic done_unc,
    output logic [47:0] done_fail_lba,
    input wire logic log_start,
    input wire logic [15:0] log_count,
    output logic log_block_done,
    output logic log_last
);
    logic [1:0] pace_reg;
    logic [15:0] left_reg;
    // Slow on purpose: accepts and blocks only every fourth cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {pace_reg, left_reg, issue_ready, done_valid, done_tag} <= '0;
            {done_unc, done_fail_lba, log_block_done, log_last} <= '0;
        end
        else
        begin
            pace_reg <= pace_reg + 2'h1;
            issue_ready <= issue_valid && !issue_ready && pace_reg == 2'h3;
            done_valid <= issue_valid && issue_ready;
            done_tag <= issue_tag;
            // Tag 5 always fails at a fixed address; otherwise the address keeps toggling
            done_unc <= issue_tag == 5'h5;
            done_fail_lba <= (issue_tag == 5'h5) ? 48'hba9876543210 : ~done_fail_lba;
            log_block_done <= left_reg != 16'h0 && pace_reg == 2'h3;
            log_last <= left_reg == 16'h1;
            if (log_start)
                left_reg <= log_count;
            else if (left_reg != 16'h0 && pace_reg == 2'h3)
                left_reg <= left_reg - 16'h1;
        end
    end
endmodule

// file: verif/qcmd_decode_tb_top.sv
// Self-checking bench for the queued read and log read decoder.
// Assumes the media model on the user side; the bench is the APB host.
`timescale 1ns/1ps
module qcmd_decode_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, irq, issue_ready, done_valid, done_unc;
    logic issue_valid, issue_fua, issue_rebuild_assist_read_flag, log_start, log_block_done, log_last;
    logic [7:0] paddr, log_addr;
    logic [31:0] pwdata, prdata, rdata;
    logic [4:0] issue_tag, done_tag;
    logic [47:0] issue_lba, done_fail_lba, seen;
    logic [15:0] issue_count, log_first, log_count;
    int miscompares = 0;
    int compares = 0;
    int irqs = 0;
    int n;
    typedef struct packed {logic [7:0] la; logic [15:0] first; logic [15:0] cnt; logic abt;} row_s;
    row_s rows [6] = '{'{8'h00, 16'h0, 16'h1, 1'b0}, '{8'h80, 16'h2, 16'h3, 1'b0}, '{8'h80, 16'hf, 16'h1, 1'b0},
        '{8'h06, 16'h0, 16'h1, 1'b1}, '{8'h80, 16'h10, 16'h1, 1'b1}, '{8'h80, 16'h0, 16'h0, 1'b1}};
    logic [15:0] qseq [12] = '{16'h0012, 16'h0034, 16'h0480, 16'h0429, 16'h0844, 16'h0811,
        16'h0c55, 16'h0c22, 16'h1066, 16'h1033, 16'h14c0, 16'h1860};
    qcmd_decode i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .issue_tag(issue_tag), .issue_valid(issue_valid), .issue_fua(issue_fua), .issue_rebuild_assist_read_flag(issue_rebuild_assist_read_flag),
        .issue_lba(issue_lba), .issue_count(issue_count), .issue_ready(issue_ready), .done_valid(done_valid),
        .done_tag(done_tag), .done_unc(done_unc), .done_fail_lba(done_fail_lba), .log_start(log_start),
        .log_addr(log_addr), .log_first(log_first), .log_count(log_count), .log_block_done(log_block_done),
        .log_last(log_last), .irq(irq));
    qcmd_media_model i_media (.pclk(pclk), .presetn(presetn), .issue_valid(issue_valid), .issue_tag(issue_tag),
        .issue_ready(issue_ready), .done_valid(done_valid), .done_tag(done_tag), .done_unc(done_unc),
        .done_fail_lba(done_fail_lba), .log_start(log_start), .log_count(log_count),
        .log_block_done(log_block_done), .log_last(log_last));
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (irq === 1'b1)
            irqs++;
        if (log_start === 1'b1)
            seen <= {log_addr, log_first, log_count};
    end
    task give_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp)
        begin
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
            miscompares++;
        end
    endtask
    task stall;
        $display("ERROR %0t wait ran out", $time);
        miscompares++;
        give_verdict();
    endtask
    // Holds the request until pready is sampled high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        rdata = prdata;
        perr = pslverr;
        {psel, penable} <= 2'b00;
        if (k >= 20)
            stall();
    endtask
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b1, qcmd_pkg::ADDR_SECNUM, rows[i].la);
            apb(1'b1, qcmd_pkg::ADDR_CYLLO, rows[i].first[15:8]);
            apb(1'b1, qcmd_pkg::ADDR_CYLLO, rows[i].first[7:0]);
            apb(1'b1, qcmd_pkg::ADDR_SECCNT, rows[i].cnt[15:8]);
            apb(1'b1, qcmd_pkg::ADDR_SECCNT, rows[i].cnt[7:0]);
            irqs = 0;
            seen = '0;
            apb(1'b1, qcmd_pkg::ADDR_COMMAND, qcmd_pkg::OP_LOGREAD);
            n = 0;
            // Busy clears once the transfer starts; data-request clears only once the log has gone out
            do begin apb(1'b0, qcmd_pkg::ADDR_STATUS, 8'h0); n++; end
            while ((rdata[7] !== 1'b0 || rdata[3] !== 1'b0) && n < 100);
            if (n >= 100)
                stall();
            chk(rdata[7:0], rows[i].abt ? 8'h41 : qcmd_pkg::STATUS_RESET);
            chk(irqs, rows[i].abt ? 1 : rows[i].cnt);
            chk(seen, rows[i].abt ? '0 : {rows[i].la, rows[i].first, rows[i].cnt});
            apb(1'b0, qcmd_pkg::ADDR_ERROR, 8'h0);
            chk(rdata[7:0], rows[i].abt ? 8'h04 : 8'h00);
        end
        // Tag 5, high priority, rebuild flag set while that feature is off; the media fails it
        foreach (qseq[i])
            apb(1'b1, qseq[i][15:8], qseq[i][7:0]);
        n = 0;
        do begin @(posedge pclk); n++; end while (issue_valid !== 1'b1 && n < 50);
        if (n >= 50)
            stall();
        chk(issue_tag, 5'h5);
        chk(issue_count, 16'h1234);
        chk(issue_lba, 48'h665544332211);
        chk(issue_fua, 1'b1);
        chk(issue_rebuild_assist_read_flag, 1'b0);
        apb(1'b0, 8'h3c, 8'h0);
        chk({perr, rdata}, 33'h100000000);
        n = 0;
        do begin apb(1'b0, qcmd_pkg::ADDR_ERROR, 8'h0); n++; end while (rdata[6] !== 1'b1 && n < 20);
        chk(rdata[7:0], 8'h40);
        apb(1'b0, qcmd_pkg::ADDR_SECNUM, 8'h0);
        chk(rdata[7:0], 8'h10);
        apb(1'b1, qcmd_pkg::ADDR_CONTROL, 8'h31);
        apb(1'b0, qcmd_pkg::ADDR_SECNUM, 8'h0);
        chk(rdata[7:0], 8'h76);
        apb(1'b0, qcmd_pkg::ADDR_CYLHI, 8'h0);
        chk(rdata[7:0], 8'hba);
        apb(1'b0, qcmd_pkg::ADDR_EVENT, 8'h0);
        chk(rdata, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, qcmd_pkg::ADDR_STATUS, 8'h0);
        chk(rdata[7:0], qcmd_pkg::STATUS_RESET);
        apb(1'b0, qcmd_pkg::ADDR_CONTROL, 8'h0);
        chk(rdata[7:0], qcmd_pkg::CONTROL_RESET);
        give_verdict();
    end
endmodule
